//--- hdl/dcc_regs.svh
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

// Register byte offsets
`define DCC_OFS_CTL 8'h00
`define DCC_OFS_SRCB 8'h04
`define DCC_OFS_DSTB 8'h08
`define DCC_OFS_TCNT 8'h0C
`define DCC_OFS_CSRC 8'h10
`define DCC_OFS_CDST 8'h14
`define DCC_OFS_CTCNT 8'h18
`define DCC_OFS_ERRINJ 8'h1C

// Control register fields
`define DCC_ERR_BIT 20
`define DCC_AUTO_BIT 19
`define DCC_TC_BIT 18
`define DCC_LOCK_BIT 17
`define DCC_SWREQ_BIT 16
`define DCC_DM_BIT 15
`define DCC_TWS_HI 13
`define DCC_TWS_LO 12
`define DCC_SINGLE_BLOCK_SELECT_BIT 11
`define DCC_BME_BIT 9
`define DCC_STOP_IRQ_ENABLE_BIT 8
`define DCC_SFIX_BIT 7
`define DCC_DFIX_BIT 6
`define DCC_SDIR_BIT 5
`define DCC_DDIR_BIT 4
`define DCC_MS_HI 3
`define DCC_MS_LO 2
`define DCC_EN_BIT 0
// Bits software may write directly
`define DCC_CTL_WMASK 32'h000BBBFD
`define DCC_CTL_RESET 32'h00000000
`define DCC_CNT_MASK 32'h00FFFFFF

// Burst length in items
`define DCC_BURST_LEN 3'h4

`endif

//--- hdl/dcc_pkg.sv
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_W8,
    DCC_W16,
    DCC_W32,
    DCC_WRSV
  } dcc_width_type;

  typedef enum logic [1:0] {
    DCC_MS_SOFT,
    DCC_MS_EXT,
    DCC_MS_RSV2,
    DCC_MS_RSV3
  } dcc_mode_type;
endpackage

//--- hdl/dcc_addr_step.sv
`timescale 1ns/1ps
`default_nettype none
// Next value of one address pointer
module dcc_addr_step
  import dcc_pkg::*;
(
  // Current pointer and controls
  input wire logic [31:0] addr,
  input wire logic fixed,
  input wire logic decr,
  input wire logic [1:0] width,
  // Result
  output logic [31:0] next_addr
);
  logic [31:0] step;

  always_comb begin
    unique case (width)
      DCC_W8: step = 32'h00000001;
      DCC_W16: step = 32'h00000002;
      default: step = 32'h00000004;
    endcase
    if (fixed) begin
      next_addr = addr;
    end else if (decr) begin
      next_addr = addr - step;
    end else begin
      next_addr = addr + step;
    end
  end
endmodule
`default_nettype wire

//--- hdl/dcc_channel.sv
// Functional notes
// - auto reload reloads current from base
// - hardware sets TC, software writes zero
// - interrupt when TC or error set
// - lock bit holds bus locked during transfer
// - software request starts, cleared on completion
// - demand mode holds bus while request
// - width field selects 8/16/32 bits
// - single needs request per op; block one
// - burst moves four items per count
// - stop interrupt when enabled on stop
// - fixed source address stays constant
// - fixed destination address stays constant
// - source direction increments or decrements
// - destination direction increments or decrements
// - mode field selects software or pin
// - enable bit; cleared on completion unless auto
// - transfer error flag raises interrupt
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`include "dcc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dcc_channel
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Peripheral request pin
  input wire logic external_request_n,
  // Data mover handshake
  output logic op_valid,
  output logic [31:0] op_src,
  output logic [31:0] op_dst,
  output logic [1:0] op_width,
  input wire logic op_done,
  input wire logic op_error,
  // System bus hold
  output logic bus_req,
  output logic bus_lock,
  input wire logic bus_grant,
  // Interrupt
  output logic channel_irq
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARB,
    ST_MOVE,
    ST_WAIT
  } dcc_state_type;

  dcc_state_type state_q, state_d;
  logic [31:0] ctl_q, ctl_d;
  logic [31:0] srcb_q, srcb_d, dstb_q, dstb_d;
  logic [23:0] tcnt_q, tcnt_d, ctcnt_q, ctcnt_d;
  logic [31:0] csrc_q, csrc_d, cdst_q, cdst_d;
  logic [2:0] beat_q, beat_d;
  logic stop_irq_q, stop_irq_d;
  logic [31:0] hrdata_d;
  logic wr_pend_q, rd_pend_q;
  logic [7:0] addr_q;
  logic [2:0] req_sync_q;
  logic req_act_q;
  logic [31:0] src_next, dst_next;
  logic op_valid_d, bus_req_d, bus_lock_d, irq_d;
  logic trigger, mode_ext, mode_soft, aphase, ctl_wr;
  logic [31:0] ctl_wdata;

  assign aphase = hsel & hready & htrans[1];
  assign mode_ext = ctl_q[`DCC_MS_HI:`DCC_MS_LO] == DCC_MS_EXT;
  assign mode_soft = ctl_q[`DCC_MS_HI:`DCC_MS_LO] == DCC_MS_SOFT;
  // soft request only in soft mode
  assign trigger = ctl_q[`DCC_EN_BIT] & ((mode_soft & ctl_q[`DCC_SWREQ_BIT])
                   | (mode_ext & req_act_q));
  assign ctl_wr = wr_pend_q & (addr_q == `DCC_OFS_CTL);
  assign ctl_wdata = hwdata;

  dcc_addr_step u_src_step (
    .addr(csrc_q),
    .fixed(ctl_q[`DCC_SFIX_BIT]),
    .decr(ctl_q[`DCC_SDIR_BIT]),
    .width(ctl_q[`DCC_TWS_HI:`DCC_TWS_LO]),
    .next_addr(src_next)
  );

  dcc_addr_step u_dst_step (
    .addr(cdst_q),
    .fixed(ctl_q[`DCC_DFIX_BIT]),
    .decr(ctl_q[`DCC_DDIR_BIT]),
    .width(ctl_q[`DCC_TWS_HI:`DCC_TWS_LO]),
    .next_addr(dst_next)
  );

  // Request pin: three stages, a change counts once stages 2 and 3 agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_sync_q <= 3'h7;
      req_act_q <= 1'b0;
    end else begin
      req_sync_q <= {req_sync_q[1:0], external_request_n};
      if (req_sync_q[1] == req_sync_q[2]) begin
        req_act_q <= ~req_sync_q[2];
      end
    end
  end

  // Bus data phase tracking; the slave never stalls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend_q <= aphase & hwrite;
      rd_pend_q <= aphase & ~hwrite;
      if (aphase) begin
        addr_q <= {haddr[7:2], 2'h0};
      end
    end
  end

  always_comb begin
    ctl_d = ctl_q;
    srcb_d = srcb_q;
    dstb_d = dstb_q;
    tcnt_d = tcnt_q;
    csrc_d = csrc_q;
    cdst_d = cdst_q;
    ctcnt_d = ctcnt_q;
    beat_d = beat_q;
    state_d = state_q;
    stop_irq_d = stop_irq_q;
    op_valid_d = 1'b0;
    bus_req_d = bus_req;
    bus_lock_d = bus_lock;

    // Software writes; TC and error flags only clear on a written zero
    if (ctl_wr) begin
      ctl_d = (ctl_q & ~`DCC_CTL_WMASK) | (ctl_wdata & `DCC_CTL_WMASK);
      if (!ctl_wdata[`DCC_TC_BIT]) begin
        ctl_d[`DCC_TC_BIT] = 1'b0;
      end
      if (!ctl_wdata[`DCC_ERR_BIT]) begin
        ctl_d[`DCC_ERR_BIT] = 1'b0;
      end
      if (!ctl_wdata[`DCC_STOP_IRQ_ENABLE_BIT]) begin
        stop_irq_d = 1'b0;
      end
    end
    if (wr_pend_q) begin
      unique case (addr_q)
        `DCC_OFS_SRCB: srcb_d = hwdata;
        `DCC_OFS_DSTB: dstb_d = hwdata;
        `DCC_OFS_TCNT: tcnt_d = hwdata[23:0];
        default: ;
      endcase
    end

    unique case (state_q)
      ST_IDLE: begin
        bus_req_d = 1'b0;
        bus_lock_d = 1'b0;
        if (trigger && ctcnt_q != 24'h000000) begin
          bus_req_d = 1'b1;
          bus_lock_d = ctl_q[`DCC_LOCK_BIT];
          state_d = ST_ARB;
        end
      end
      ST_ARB: begin
        if (bus_grant) begin
          op_valid_d = 1'b1;
          beat_d = 3'h0;
          state_d = ST_MOVE;
        end
      end
      ST_MOVE: begin
        op_valid_d = 1'b1;
        if (op_done) begin
          op_valid_d = 1'b0;
          csrc_d = src_next;
          cdst_d = dst_next;
          beat_d = beat_q + 3'h1;
          state_d = ST_WAIT;
          if (op_error) begin
            ctl_d[`DCC_ERR_BIT] = 1'b1;
            // A failed item stops the channel; left enabled it would retry forever
            ctl_d[`DCC_EN_BIT] = 1'b0;
            if (ctl_q[`DCC_STOP_IRQ_ENABLE_BIT]) begin
              stop_irq_d = 1'b1;
            end
            state_d = ST_IDLE;
            bus_req_d = 1'b0;
            bus_lock_d = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        // four items per count in burst
        if (ctl_q[`DCC_BME_BIT] && beat_q != `DCC_BURST_LEN) begin
          op_valid_d = 1'b1;
          state_d = ST_MOVE;
        end else begin
          ctcnt_d = ctcnt_q - 24'h000001;
          beat_d = 3'h0;
          if (ctcnt_q == 24'h000001) begin
            ctl_d[`DCC_TC_BIT] = 1'b1;
            ctl_d[`DCC_SWREQ_BIT] = 1'b0;
            if (ctl_q[`DCC_STOP_IRQ_ENABLE_BIT]) begin
              stop_irq_d = 1'b1;
            end
            if (ctl_q[`DCC_AUTO_BIT]) begin
              csrc_d = srcb_q;
              cdst_d = dstb_q;
              ctcnt_d = tcnt_q;
            end else begin
              ctl_d[`DCC_EN_BIT] = 1'b0;
            end
            state_d = ST_IDLE;
            bus_req_d = 1'b0;
            bus_lock_d = 1'b0;
          end else if (mode_soft || (ctl_q[`DCC_SINGLE_BLOCK_SELECT_BIT] && !ctl_q[`DCC_DM_BIT])
                       || (ctl_q[`DCC_DM_BIT] && req_act_q)) begin
            op_valid_d = 1'b1;
            state_d = ST_MOVE;
          end else begin
            // single mode waits for next request
            state_d = ST_IDLE;
            bus_req_d = 1'b0;
            bus_lock_d = 1'b0;
          end
        end
      end
    endcase

    // Enabling loads the current registers from the bases
    if (ctl_wr && ctl_wdata[`DCC_EN_BIT] && !ctl_q[`DCC_EN_BIT]) begin
      csrc_d = srcb_q;
      cdst_d = dstb_q;
      ctcnt_d = tcnt_q;
    end

    // interrupt from TC, error or stop
    irq_d = ctl_d[`DCC_TC_BIT] | ctl_d[`DCC_ERR_BIT] | stop_irq_d;

    hrdata_d = 32'h00000000;
    if (aphase && !hwrite) begin
      unique case ({haddr[7:2], 2'h0})
        `DCC_OFS_CTL: hrdata_d = ctl_q;
        `DCC_OFS_SRCB: hrdata_d = srcb_q;
        `DCC_OFS_DSTB: hrdata_d = dstb_q;
        `DCC_OFS_TCNT: hrdata_d = {8'h00, tcnt_q};
        `DCC_OFS_CSRC: hrdata_d = csrc_q;
        `DCC_OFS_CDST: hrdata_d = cdst_q;
        `DCC_OFS_CTCNT: hrdata_d = {8'h00, ctcnt_q};
        default: hrdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      ctl_q <= `DCC_CTL_RESET;
      srcb_q <= 32'h00000000;
      dstb_q <= 32'h00000000;
      tcnt_q <= 24'h000000;
      csrc_q <= 32'h00000000;
      cdst_q <= 32'h00000000;
      ctcnt_q <= 24'h000000;
      beat_q <= 3'h0;
      stop_irq_q <= 1'b0;
      op_valid <= 1'b0;
      bus_req <= 1'b0;
      bus_lock <= 1'b0;
      channel_irq <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      state_q <= state_d;
      ctl_q <= ctl_d;
      srcb_q <= srcb_d;
      dstb_q <= dstb_d;
      tcnt_q <= tcnt_d;
      csrc_q <= csrc_d;
      cdst_q <= cdst_d;
      ctcnt_q <= ctcnt_d;
      beat_q <= beat_d;
      stop_irq_q <= stop_irq_d;
      op_valid <= op_valid_d;
      bus_req <= bus_req_d;
      bus_lock <= bus_lock_d;
      channel_irq <= irq_d;
      hrdata <= hrdata_d;
    end
  end

  // Fixed answers: always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_src <= 32'h00000000;
      op_dst <= 32'h00000000;
      op_width <= 2'h0;
    end else begin
      op_src <= csrc_d;
      op_dst <= cdst_d;
      op_width <= ctl_d[`DCC_TWS_HI:`DCC_TWS_LO];
    end
  end

  a_irq_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctl_q[`DCC_TC_BIT] | ctl_q[`DCC_ERR_BIT]) |-> channel_irq)
    else $error("irq low while flag set");

  a_lock_bit: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(bus_lock) |-> ctl_q[`DCC_LOCK_BIT])
    else $error("bus locked without lock bit");

  a_en_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ($rose(ctl_q[`DCC_TC_BIT]) && !ctl_q[`DCC_AUTO_BIT]) |-> !ctl_q[`DCC_EN_BIT])
    else $error("enable not cleared at completion");

  a_swreq_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ctl_q[`DCC_TC_BIT]) |-> !ctl_q[`DCC_SWREQ_BIT])
    else $error("soft request not cleared");

  // TC rises only in the cycle after ST_WAIT
  a_tc_set: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ctl_q[`DCC_TC_BIT]) |-> $past(state_q) == ST_WAIT)
    else $error("tc set outside completion");

  a_mode_rsv: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_IDLE && ctl_q[`DCC_MS_HI]) |=> state_q == ST_IDLE)
    else $error("reserved mode started a transfer");

  a_src_fixed: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_MOVE && op_done && ctl_q[`DCC_SFIX_BIT]) |=>
    csrc_q == $past(csrc_q) || ctl_q[`DCC_TC_BIT])
    else $error("fixed source address moved");

  // demand holds bus while request active
  a_demand_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == ST_WAIT && ctl_q[`DCC_DM_BIT] && mode_ext && req_act_q
     && !ctl_q[`DCC_BME_BIT] && ctcnt_q > 24'h000001) |=> bus_req)
    else $error("demand mode released bus early");
endmodule
`default_nettype wire

//--- dv/dcc_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcc_periph_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench controls
  input wire logic req_on,
  input wire logic err_on,
  // Channel side
  input wire logic op_valid,
  input wire logic bus_req,
  output logic external_request_n,
  output logic op_done,
  output logic op_error,
  output logic bus_grant
);
  logic [1:0] wait_q;
  logic [1:0] lat_q;
  assign external_request_n = ~req_on;
  // Latency cycles 0..3 so prompt and slow answers both occur
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 2'h0;
      lat_q <= 2'h0;
      op_done <= 1'b0;
      op_error <= 1'b0;
      bus_grant <= 1'b0;
    end else begin
      bus_grant <= bus_req;
      op_done <= 1'b0;
      op_error <= 1'b0;
      if (op_valid && !op_done) begin
        if (wait_q == lat_q) begin
          op_done <= 1'b1;
          op_error <= err_on;
          wait_q <= 2'h0;
          lat_q <= lat_q + 2'h1;
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/dma_channel_control_test.sv
`include "dcc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_test;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, req_on, err_on;
  logic external_request_n, op_valid, op_done, op_error, bus_req, bus_lock, bus_grant;
  logic channel_irq;
  logic [31:0] haddr, hwdata, hrdata, op_src, op_dst, sb, db, e_src, e_dst, e_ctl, r;
  logic [1:0] htrans, op_width, e_w, w;
  logic [2:0] hsize;
  int bad_count, samples_checked, seed, seen, k;

  initial hclk = 1'b0;
  always #10 hclk = ~hclk;
  assign hready = hreadyout;

  dcc_channel dcc_channel_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_request_n(external_request_n), .op_valid(op_valid), .op_src(op_src),
    .op_dst(op_dst), .op_width(op_width), .op_done(op_done), .op_error(op_error),
    .bus_req(bus_req), .bus_lock(bus_lock), .bus_grant(bus_grant),
    .channel_irq(channel_irq));
  dcc_periph_model dcc_periph_model_i (.hclk(hclk), .hresetn(hresetn), .req_on(req_on),
    .err_on(err_on), .op_valid(op_valid), .bus_req(bus_req),
    .external_request_n(external_request_n), .op_done(op_done), .op_error(op_error),
    .bus_grant(bus_grant));

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Single word transfer; slave latency is taken from hready, never assumed
  task ahb(input logic wr_en, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr_en;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] a, input logic f, input logic dn,
                                      input logic [1:0] wd);
    if (f) return a;
    return dn ? a - (32'h1 << wd) : a + (32'h1 << wd);
  endfunction

  // Every accepted item is compared with the address walk worked out here
  always @(posedge hclk) begin
    if (op_valid === 1'b1 && op_done === 1'b1) begin
      chk("op_src", op_src, e_src);
      chk("op_dst", op_dst, e_dst);
      chk("op_width", 32'(op_width), 32'(e_w));
      chk("bus_lock", 32'(bus_lock), 32'(e_ctl[17]));
      if (e_ctl[15]) chk("bus_hold", 32'(bus_req), 1);
      e_src = nxt(e_src, e_ctl[7], e_ctl[5], e_w);
      e_dst = nxt(e_dst, e_ctl[6], e_ctl[4], e_w);
      seen = seen + 1;
    end
  end

  task run(input logic [31:0] ctl, input logic [31:0] cnt);
    int n;
    int q;
    e_ctl = ctl;
    e_w = ctl[13:12];
    e_src = sb;
    e_dst = db;
    seen = 0;
    ahb(1'b1, `DCC_OFS_CTL, 32'h0);
    ahb(1'b1, `DCC_OFS_SRCB, sb);
    ahb(1'b1, `DCC_OFS_DSTB, db);
    ahb(1'b1, `DCC_OFS_TCNT, cnt);
    ahb(1'b1, `DCC_OFS_CTL, ctl);
    for (q = 0; ctl[3:2] == 2'b01 && q < ((ctl[11] | ctl[15]) ? 1 : cnt); q++) begin
      req_on <= 1'b1;
      repeat (2) @(posedge hclk);
      req_on <= ctl[15];
      n = 0;
      while (seen <= q && n < 300) begin
        @(posedge hclk);
        n++;
      end
      repeat (4) @(posedge hclk);
    end
    n = 0;
    r = 32'h0;
    while (r[18] !== 1'b1 && r[20] !== 1'b1 && n < 400) begin
      ahb(1'b0, `DCC_OFS_CTL, 32'h0);
      n++;
    end
    req_on <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("irq", 32'(channel_irq), 1);
    if (err_on) begin
      chk("err_flag", 32'(r[20]), 1);
    end else begin
      chk("items", seen, cnt * (ctl[9] ? 32'h4 : 32'h1));
      ahb(1'b0, `DCC_OFS_CTL, 32'h0);
      chk("tc_flag", 32'(r[18]), 1);
      chk("soft_req", 32'(r[16]), 0);
      chk("enable", 32'(r[0]), 32'(ctl[19]));
      ahb(1'b0, `DCC_OFS_CSRC, 32'h0);
      chk("cur_src", r, ctl[19] ? sb : e_src);
      ahb(1'b0, `DCC_OFS_CDST, 32'h0);
      chk("cur_dst", r, ctl[19] ? db : e_dst);
      ahb(1'b0, `DCC_OFS_CTCNT, 32'h0);
      chk("cur_cnt", r, ctl[19] ? cnt : 32'h0);
      // Writing zero to every bit but the stop interrupt enable leaves the stop cause behind the interrupt
      ahb(1'b1, `DCC_OFS_CTL, ctl & 32'h0000_0100);
      repeat (2) @(posedge hclk);
      chk("stop_irq", 32'(channel_irq), 32'(ctl[8]));
    end
    ahb(1'b1, `DCC_OFS_CTL, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq_clear", 32'(channel_irq), 0);
    $display("test done ctl %h count %0d", ctl, cnt);
  endtask

  initial begin
    seed = 52960;
    bad_count = 0;
    samples_checked = 0;
    seen = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    req_on = 1'b0;
    err_on = 1'b0;
    e_ctl = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b1, 32'h20, 32'hFFFF_FFFF);
    for (k = 0; k <= 32'h20; k += 4) begin
      ahb(1'b0, 32'(k), 32'h0);
      chk("reset_value", r, 32'h0);
    end
    sb = 32'h0000_1000;
    db = 32'h0000_2000;
    run(32'h0001_2001, 32'h2);
    run(32'h0003_1391, 32'h2);
    run(32'h0009_0001, 32'h3);
    run(32'h0000_2005, 32'h3);
    run(32'h0000_0845, 32'h3);
    run(32'h0000_A005, 32'h4);
    for (k = 0; k < 8; k++) begin
      w = 2'({$random(seed)} % 3);
      sb = $random(seed) & (32'hFFFF_FFFF << w);
      db = $random(seed) & (32'hFFFF_FFFF << w);
      run(32'h0001_0001 | (32'(w) << 12) | ($random(seed) & 32'h000A_03F0),
          32'(1 + {$random(seed)} % 3));
    end
    err_on <= 1'b1;
    run(32'h0001_2001, 32'h1);
    err_on <= 1'b0;
    seen = 0;
    ahb(1'b1, `DCC_OFS_CTL, 32'h0001_0009);
    repeat (40) @(posedge hclk);
    chk("reserved_mode_items", seen, 32'h0);
    ahb(1'b1, `DCC_OFS_CTL, 32'h0);
    final_report;
  end

  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    final_report;
  end
endmodule
`default_nettype wire
